/* pkg/buck_ctl_pkg.sv */
package buck_ctl_pkg;

	// ----------------------------------------
	// timing, clock of 250 MHz
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PS_PER_NS = 1000;
	localparam int PS_PER_KHZ = 1000000000;
	localparam int OV_TIME_NS = 4000;
	localparam int OV_CYC =
		(OV_TIME_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OV_W = $clog2(OV_CYC + 1);
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC =
		(BLANK_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_W = $clog2(BLANK_CYC + 1);
	localparam int MAX_OFF_NS = 7500;
	localparam int MAX_OFF_CYC = (MAX_OFF_NS * PS_PER_NS) / CLK_PERIOD_PS;

	// ----------------------------------------
	// switching frequencies
	// ----------------------------------------
	localparam int SYNC_MIN_KHZ = 200;
	localparam int SYNC_MAX_KHZ = 1500;
	localparam int FIXED_KHZ = 1000;
	localparam int SYNC_MAX_PER = PS_PER_KHZ / (SYNC_MIN_KHZ * CLK_PERIOD_PS);
	localparam int SYNC_MIN_PER = (PS_PER_KHZ + SYNC_MAX_KHZ * CLK_PERIOD_PS
		- 1) / (SYNC_MAX_KHZ * CLK_PERIOD_PS);
	localparam int FIXED_PER = PS_PER_KHZ / (FIXED_KHZ * CLK_PERIOD_PS);
	localparam int CNT_W = 12;

	// ----------------------------------------
	// fault sequencing counts
	// ----------------------------------------
	localparam int HICCUP_SW_CYC = 4096;
	localparam int SS_SW_CYC = 400;
	localparam int SW_W = 13;
	localparam int SKIP_W = 4;
	localparam logic [SKIP_W-1:0] SKIP_LAST = 4'hf;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic vin_below_off;
		logic vin_above_on;
		logic node_shutdown;
		logic node_above_2v;
		logic out_over;
		logic ls_current_limit_set_pin;
		logic hs_oc;
		logic pwm_off;
		logic sync_node_high;
	} cmp_t;

	typedef struct packed {
		logic hs;
		logic ls;
	} gate_t;

	typedef enum logic [2:0] {
		ST_LOCKOUT,
		ST_SHUTDOWN,
		ST_OVP,
		ST_HICCUP,
		ST_SOFTSTART,
		ST_RUN
	} state_t;

endpackage

/* hw/buck_fault_sync_control.sv */
module buck_fault_sync_control #(
	parameter int HICCUP_CYCLES = buck_ctl_pkg::HICCUP_SW_CYC,
	parameter int SS_CYCLES = buck_ctl_pkg::SS_SW_CYC
)(
	// clocks and reset
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SYNC_CLK,
	// analog side
	input wire logic [buck_ctl_pkg::CNT_W-1:0] FREQ_SET_PERIOD,
	input wire buck_ctl_pkg::cmp_t CMP,
	// power stage
	output buck_ctl_pkg::gate_t GATE,
	// status
	output logic SOFT_START,
	output logic HICCUP,
	output logic OVP_LATCHED,
	output logic SYNC_LOCKED
);
	localparam int CW = buck_ctl_pkg::CNT_W;
	localparam int NC = $bits(buck_ctl_pkg::cmp_t);
	localparam int SWW = buck_ctl_pkg::SW_W;
	localparam int OW = buck_ctl_pkg::OV_W;
	localparam int BW = buck_ctl_pkg::BLANK_W;
	localparam int KW = buck_ctl_pkg::SKIP_W;

	// ----------------------------------------
	// link domain: one toggle per sync edge
	// ----------------------------------------
	logic lrst_meta_ff;
	logic lrst_ff;
	logic sync_tgl_ff;

	// cleared at once: link clock may idle through reset
	always_ff @(posedge SYNC_CLK or posedge SRST)
	begin
		if (SRST)
		begin
			lrst_meta_ff <= 1'b1;
			lrst_ff <= 1'b1;
			sync_tgl_ff <= 1'b0;
		end
		else
		begin
			lrst_meta_ff <= 1'b0;
			lrst_ff <= lrst_meta_ff;
			if (lrst_ff)
				sync_tgl_ff <= 1'b0;
			else
				sync_tgl_ff <= ~sync_tgl_ff;
		end
	end

	// ----------------------------------------
	// synchronisers into the switching clock
	// ----------------------------------------
	logic [NC-1:0] cmp_meta_ff;
	logic [NC-1:0] cmp_sync_ff;
	logic [2:0] tgl_ff;
	buck_ctl_pkg::cmp_t cs;

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cmp_meta_ff <= '0;
			cmp_sync_ff <= '0;
			tgl_ff <= 3'h0;
		end
		else
		begin
			cmp_meta_ff <= CMP;
			cmp_sync_ff <= cmp_meta_ff;
			tgl_ff <= {tgl_ff[1:0], sync_tgl_ff};
		end
	end

	assign cs = cmp_sync_ff;

	// ----------------------------------------
	// oscillator and sync tracking
	// ----------------------------------------
	logic [CW-1:0] cyc_cnt_ff;
	logic [CW-1:0] edge_cnt_ff;
	logic [CW-1:0] sync_per_ff;
	logic sync_ff;
	logic fixed_ff;
	wire ext_edge = tgl_ff[2] ^ tgl_ff[1];
	wire edge_ok = ext_edge &&
		edge_cnt_ff >= CW'(buck_ctl_pkg::SYNC_MIN_PER);
	wire edge_lock = edge_ok &&
		edge_cnt_ff <= CW'(buck_ctl_pkg::SYNC_MAX_PER);
	wire [CW-1:0] tmo = sync_per_ff + (sync_per_ff >> 1);
	wire [CW-1:0] free_lim = fixed_ff ?
		CW'(buck_ctl_pkg::FIXED_PER) : FREQ_SET_PERIOD;
	wire [CW-1:0] lim = sync_ff ? tmo : free_lim;
	wire lim_hit = cyc_cnt_ff >= lim - CW'(1);
	wire cap_hit = cyc_cnt_ff >= CW'(buck_ctl_pkg::MAX_OFF_CYC - 1);
	wire sync_tmo = sync_ff && lim_hit && !edge_ok;
	wire cyc_start = edge_ok || lim_hit || cap_hit;
	wire edge_sat = &edge_cnt_ff;

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cyc_cnt_ff <= '0;
			edge_cnt_ff <= '1;
			sync_per_ff <= '0;
			sync_ff <= 1'b0;
			fixed_ff <= 1'b0;
		end
		else
		begin
			cyc_cnt_ff <= cyc_start ? '0 : cyc_cnt_ff + CW'(1);
			edge_cnt_ff <= ext_edge ? '0 :
				(edge_sat ? edge_cnt_ff : edge_cnt_ff + CW'(1));
			if (edge_lock)
				sync_per_ff <= edge_cnt_ff;
			if (edge_lock)
				sync_ff <= 1'b1;
			else if (sync_tmo)
				sync_ff <= 1'b0;
			if (edge_lock)
				fixed_ff <= 1'b0;
			else if (sync_tmo && cs.sync_node_high)
				fixed_ff <= 1'b1;
			else if (!cs.sync_node_high)
				fixed_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// fault detection
	// ----------------------------------------
	buck_ctl_pkg::state_t state_ff;
	buck_ctl_pkg::state_t nxt_state;
	logic lockout_ff;
	logic [OW-1:0] ov_cnt_ff;
	logic [BW-1:0] blank_cnt_ff;
	logic [KW-1:0] skip_cnt_ff;
	logic [SWW-1:0] sw_cnt_ff;
	logic skip_ff;
	wire in_lockout = cs.vin_below_off ||
		(lockout_ff && !cs.vin_above_on);
	wire sd = cs.node_shutdown;
	wire in_ss = state_ff == buck_ctl_pkg::ST_SOFTSTART;
	wire in_run = state_ff == buck_ctl_pkg::ST_RUN;
	wire in_hiccup = state_ff == buck_ctl_pkg::ST_HICCUP;
	wire switching = in_ss || in_run;
	wire ov_trip = cs.out_over && ov_cnt_ff == OW'(buck_ctl_pkg::OV_CYC);
	wire hs_trip = GATE.hs && blank_cnt_ff == '0 && cs.hs_oc;
	wire skip_now = cyc_start && skip_ff && switching;
	wire cnt_trip = in_run && skip_now && cs.node_above_2v &&
		skip_cnt_ff == buck_ctl_pkg::SKIP_LAST;
	wire hiccup_done = in_hiccup && cyc_start &&
		sw_cnt_ff == SWW'(HICCUP_CYCLES - 1);
	wire ss_done = in_ss && cyc_start && sw_cnt_ff == SWW'(SS_CYCLES - 1);

	always_comb
	begin
		nxt_state = state_ff;
		if (in_lockout)
			nxt_state = buck_ctl_pkg::ST_LOCKOUT;
		else if (sd)
			nxt_state = buck_ctl_pkg::ST_SHUTDOWN;
		else
			case (state_ff)
				buck_ctl_pkg::ST_LOCKOUT,
				buck_ctl_pkg::ST_SHUTDOWN:
					nxt_state = buck_ctl_pkg::ST_SOFTSTART;
				buck_ctl_pkg::ST_OVP:
					nxt_state = buck_ctl_pkg::ST_OVP;
				buck_ctl_pkg::ST_HICCUP:
					if (ov_trip)
						nxt_state = buck_ctl_pkg::ST_OVP;
					else if (hiccup_done)
						nxt_state = buck_ctl_pkg::ST_SOFTSTART;
				buck_ctl_pkg::ST_SOFTSTART:
					if (ov_trip)
						nxt_state = buck_ctl_pkg::ST_OVP;
					else if (hs_trip)
						nxt_state = buck_ctl_pkg::ST_HICCUP;
					else if (ss_done)
						nxt_state = buck_ctl_pkg::ST_RUN;
				buck_ctl_pkg::ST_RUN:
					if (ov_trip)
						nxt_state = buck_ctl_pkg::ST_OVP;
					else if (hs_trip || cnt_trip)
						nxt_state = buck_ctl_pkg::ST_HICCUP;
				default:
					nxt_state = buck_ctl_pkg::ST_LOCKOUT;
			endcase
	end

	// ----------------------------------------
	// gate drive decode
	// ----------------------------------------
	wire nxt_hs = !switching ? 1'b0 :
		(cyc_start ? !skip_ff : (cs.pwm_off ? 1'b0 : GATE.hs));
	wire nxt_ls = (state_ff == buck_ctl_pkg::ST_OVP) ||
		(switching && !nxt_hs);
	wire nxt_skip = (GATE.ls && cs.ls_current_limit_set_pin) ? 1'b1 :
		(cyc_start ? 1'b0 : skip_ff);
	wire [KW-1:0] nxt_skip_cnt = (!cs.node_above_2v || !in_run) ? '0 :
		(skip_now ? skip_cnt_ff + KW'(1) :
		(cyc_start ? '0 : skip_cnt_ff));
	wire [BW-1:0] nxt_blank = (nxt_hs && !GATE.hs) ?
		BW'(buck_ctl_pkg::BLANK_CYC) :
		(blank_cnt_ff == '0 ? '0 : blank_cnt_ff - BW'(1));
	wire [OW-1:0] nxt_ov = !cs.out_over ? '0 :
		(ov_trip ? ov_cnt_ff : ov_cnt_ff + OW'(1));
	wire [SWW-1:0] nxt_sw = (nxt_state != state_ff) ? '0 :
		(cyc_start ? sw_cnt_ff + SWW'(1) : sw_cnt_ff);

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state_ff <= buck_ctl_pkg::ST_LOCKOUT;
			lockout_ff <= 1'b1;
			ov_cnt_ff <= '0;
			blank_cnt_ff <= '0;
			skip_cnt_ff <= '0;
			sw_cnt_ff <= '0;
			skip_ff <= 1'b0;
			GATE <= '0;
			SOFT_START <= 1'b0;
			HICCUP <= 1'b0;
			OVP_LATCHED <= 1'b0;
			SYNC_LOCKED <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			lockout_ff <= in_lockout;
			ov_cnt_ff <= nxt_ov;
			blank_cnt_ff <= nxt_blank;
			skip_cnt_ff <= nxt_skip_cnt;
			sw_cnt_ff <= nxt_sw;
			skip_ff <= nxt_skip;
			GATE <= '{hs: nxt_hs, ls: nxt_ls};
			SOFT_START <= in_ss;
			HICCUP <= in_hiccup;
			OVP_LATCHED <= state_ff == buck_ctl_pkg::ST_OVP;
			SYNC_LOCKED <= sync_ff;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	chk_input_undervoltage_lockout_entry: assert property (
		cs.vin_below_off |=> state_ff == buck_ctl_pkg::ST_LOCKOUT
			##1 (!GATE.hs && !GATE.ls))
		else $error("lockout not entered with switches off");
	chk_input_undervoltage_lockout_hold: assert property (
		state_ff == buck_ctl_pkg::ST_LOCKOUT && !cs.vin_above_on
			|=> state_ff == buck_ctl_pkg::ST_LOCKOUT)
		else $error("lockout left without good input");
	chk_sd_off: assert property (
		sd && !in_lockout |=> state_ff == buck_ctl_pkg::ST_SHUTDOWN
			##1 (!GATE.hs && !GATE.ls))
		else $error("shutdown did not disable switches");
	chk_ovp_trip: assert property (
		ov_trip && (switching || in_hiccup) && !in_lockout && !sd |=>
			state_ff == buck_ctl_pkg::ST_OVP ##1 (!GATE.hs && GATE.ls))
		else $error("overvoltage latch or gates wrong");
	chk_ovp_delay: assert property (
		$rose(state_ff == buck_ctl_pkg::ST_OVP) |->
			$past(ov_cnt_ff) == OW'(buck_ctl_pkg::OV_CYC))
		else $error("overvoltage latched at wrong time");
	chk_ovp_hold: assert property (
		state_ff == buck_ctl_pkg::ST_OVP && !in_lockout && !sd
			|=> state_ff == buck_ctl_pkg::ST_OVP)
		else $error("overvoltage latch cleared wrongly");
	chk_skip_gate: assert property (
		skip_now && !in_lockout && !sd |=> !GATE.hs && GATE.ls)
		else $error("skipped cycle drove high side");
	chk_skip_clear: assert property (
		!cs.node_above_2v |=> skip_cnt_ff == '0)
		else $error("skip counter not cleared");
	chk_cnt_hiccup: assert property (
		cnt_trip && !in_lockout && !sd && !ov_trip
			|=> state_ff == buck_ctl_pkg::ST_HICCUP)
		else $error("sixteenth skip did not start hiccup");
	chk_ss_no_cnt: assert property (
		in_ss && !hs_trip |=> state_ff != buck_ctl_pkg::ST_HICCUP)
		else $error("soft-start entered hiccup by counting");
	chk_hs_trip: assert property (
		hs_trip && switching && !in_lockout && !sd && !ov_trip
			|=> state_ff == buck_ctl_pkg::ST_HICCUP)
		else $error("high-side overcurrent missed");
	chk_blank_load: assert property (
		$rose(GATE.hs) |-> blank_cnt_ff == BW'(buck_ctl_pkg::BLANK_CYC))
		else $error("blanking not started at turn-on");
	chk_max_off: assert property (
		cyc_cnt_ff < CW'(buck_ctl_pkg::MAX_OFF_CYC))
		else $error("switching cycle too long");
	chk_sync_tmo: assert property (
		sync_tmo |=> !sync_ff && cyc_cnt_ff == '0)
		else $error("sync timeout not handled");

	cov_hiccup: cover property ($rose(in_hiccup));
	cov_ovp: cover property ($rose(state_ff == buck_ctl_pkg::ST_OVP));
	cov_lock: cover property ($rose(sync_ff));
	cov_fixed: cover property ($rose(fixed_ff));

endmodule

/* bench/buck_power_stage_model.sv */
module buck_power_stage_model (
	// clock and bench control
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] sync_mode,
	input wire logic [15:0] per_ns,
	input wire logic [7:0] on_len,
	input wire logic current_limit_set_pin_en,
	input wire logic oc_en,
	// power stage
	input wire buck_ctl_pkg::gate_t gate,
	output logic ls_current_limit_set_pin,
	output logic hs_oc,
	output logic pwm_off,
	output logic sync_clk
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] on_cnt;

	always_ff @(posedge clk)
		on_cnt <= gate.hs ? on_cnt + 8'h01 : 8'h00;

	assign pwm_off = gate.hs && on_cnt >= on_len;
	assign ls_current_limit_set_pin = current_limit_set_pin_en && gate.ls;
	assign hs_oc = oc_en && gate.hs;

	// ----
	// sync source: free toggle in reset, pulses or stuck level after
	// ----
	initial
	begin
		sync_clk = 1'b0;
		#1;
		forever
		begin
			if (rst)
				#15 sync_clk = ~sync_clk;
			else if (sync_mode == 2'd1)
			begin
				sync_clk = 1'b1;
				#(per_ns / 2) sync_clk = 1'b0;
				#(per_ns / 2);
			end
			else
				#15 sync_clk = sync_mode[1];
		end
	end
endmodule

/* bench/buck_fault_sync_control_tb_top.sv */
module buck_fault_sync_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		string nm;
		bit pc;
		logic [15:0] e;
		logic [5:0] m;
		int w;
	} note_t;

	logic CLK, SRST, sclk, current_limit_set_pin, oc, poff, current_limit_set_pin_en, oc_en;
	logic vin_lo, vin_ok, sd, n2v, ov, snh, hs_q;
	logic ss, hic, ovp, lock;
	logic [1:0] smode;
	logic [15:0] per_ns, per, pcnt;
	logic [7:0] on_len;
	buck_ctl_pkg::cmp_t cmp;
	buck_ctl_pkg::gate_t gate;
	note_t q[$];
	int error_cnt = 0;
	int n_compared = 0;
	int age = 0;
	wire logic [5:0] obs = {gate, ss, hic, ovp, lock};

	assign cmp = {vin_lo, vin_ok, sd, n2v, ov, current_limit_set_pin, oc, poff, snh};

	buck_fault_sync_control #(.HICCUP_CYCLES(8), .SS_CYCLES(4)) dut (
		.CLK(CLK),
		.SRST(SRST),
		.SYNC_CLK(sclk),
		.FREQ_SET_PERIOD(12'h064),
		.CMP(cmp),
		.GATE(gate),
		.SOFT_START(ss),
		.HICCUP(hic),
		.OVP_LATCHED(ovp),
		.SYNC_LOCKED(lock)
	);

	buck_power_stage_model stage (
		.clk(CLK),
		.rst(SRST),
		.sync_mode(smode),
		.per_ns(per_ns),
		.on_len(on_len),
		.current_limit_set_pin_en(current_limit_set_pin_en),
		.oc_en(oc_en),
		.gate(gate),
		.ls_current_limit_set_pin(current_limit_set_pin),
		.hs_oc(oc),
		.pwm_off(poff),
		.sync_clk(sclk)
	);

	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// ----
	// monitor: switching period and oldest note
	// ----
	always @(posedge CLK)
	begin
		hs_q <= gate.hs;
		pcnt <= (gate.hs && !hs_q) ? 16'h0001 : pcnt + 16'h0001;
		if (gate.hs && !hs_q)
			per <= pcnt;
	end

	function automatic bit hit(note_t n);
		if (n.pc)
			return per + 16'h0002 - n.e <= 16'h0004;
		return (obs & n.m) === n.e[5:0];
	endfunction

	always @(posedge CLK)
	begin
		#2;
		if (q.size() > 0)
		begin
			if (hit(q[0]) || age >= q[0].w)
			begin
				n_compared++;
				if (!hit(q[0]))
				begin
					error_cnt++;
					$display("[ERR] %s expected %0h seen %0h per %0d",
						q[0].nm, q[0].e, obs, per);
				end
				void'(q.pop_front());
				age = 0;
			end
			else
				age++;
		end
	end

	task automatic cyc(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic chk(string nm, bit pc, logic [15:0] e, logic [5:0] m,
		int w);
		int k;
		k = 0;
		q.push_back('{nm, pc, e, m, w});
		while (q.size() > 0 && k < w + 4)
		begin
			cyc(1);
			k++;
		end
	endtask

	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		test_done();
	end

	// ----
	// stimulus
	// ----
	initial
	begin
		SRST = 1'b1;
		{vin_lo, vin_ok, sd, n2v, ov, snh, current_limit_set_pin_en, oc_en} = 8'h80;
		smode = 2'd0;
		per_ns = 16'd2000;
		void'($urandom(38));
		on_len = 8'(60 + $urandom_range(25));
		cyc(12);
		SRST = 1'b0;
		chk("reset", 0, 0, 6'h3f, 0);
		cyc(20);
		chk("lockout", 0, 0, 6'h3f, 0);
		vin_lo = 1'b0;
		vin_ok = 1'b1;
		chk("softstart", 0, 6'h08, 6'h0e, 10);
		chk("run", 0, 0, 6'h0e, 600);
		chk("own rate", 1, 16'd100, 0, 400);
		for (int i = 0; i < 2; i++)
		begin
			per_ns = 16'(4 * (300 + $urandom_range(600)));
			smode = 2'd1;
			chk("lock", 0, 1, 1, 4000);
			chk("sync rate", 1, per_ns / 4, 0, 3000);
			smode = 2'(2 * i);
			snh = i[0];
			chk("unlock", 0, 0, 1, per_ns * 3 / 4);
			chk("fallback", 1, i ? 250 : 100, 0, 3000);
			snh = 1'b0;
			chk("decayed", 1, 16'd100, 0, 2000);
		end
		ov = 1'b1;
		cyc(950);
		chk("ovp early", 0, 0, 6'h02, 0);
		chk("ovp latch", 0, 6'h12, 6'h3a, 200);
		ov = 1'b0;
		cyc(50);
		chk("ovp held", 0, 6'h12, 6'h3a, 0);
		sd = 1'b1;
		chk("shutdown", 0, 0, 6'h3e, 10);
		current_limit_set_pin_en = 1'b1;
		n2v = 1'b1;
		sd = 1'b0;
		chk("restart", 0, 6'h08, 6'h0e, 10);
		cyc(300);
		chk("ss no hiccup", 0, 0, 6'h04, 0);
		chk("ss end", 0, 0, 6'h0c, 200);
		cyc(1000);
		n2v = 1'b0;
		cyc(10);
		n2v = 1'b1;
		cyc(1000);
		chk("count cleared", 0, 0, 6'h04, 0);
		chk("skip hiccup", 0, 6'h04, 6'h3c, 800);
		current_limit_set_pin_en = 1'b0;
		cyc(700);
		chk("cooldown", 0, 6'h04, 6'h3c, 0);
		chk("cooldown end", 0, 6'h08, 6'h0e, 200);
		chk("run again", 0, 0, 6'h0e, 600);
		on_len = 8'd40;
		oc_en = 1'b1;
		cyc(500);
		chk("blanked", 0, 0, 6'h04, 0);
		on_len = 8'(60 + $urandom_range(25));
		chk("hs trip", 0, 6'h04, 6'h3c, 200);
		vin_lo = 1'b1;
		vin_ok = 1'b0;
		chk("lockout wins", 0, 0, 6'h3e, 10);
		test_done();
	end
endmodule
